/* iag_pkg.sv */
// shared constants and types of the indirect address generation block
`default_nettype none
package iag_pkg;
	localparam int          REG_AW        = 8;
	localparam int          DATA_W        = 16;
	localparam int          PHYS_W        = 24;
	localparam int          PAGE_W        = 10;
	localparam int          SEG_W         = 8;
	localparam int          PAGE_OFS_W    = 14;
	localparam int          PAGE_SEL_HI   = 15;
	localparam int          PAGE_SEL_LO   = 14;
	localparam int          DUAL_PORT_DATA_RAM_OFS_W   = 12;
	localparam int          NUM_PAIR      = 2;
	localparam int          NUM_PAGE      = 4;
	localparam logic [7:0]  REG_GOFS0     = 8'h00;
	localparam logic [7:0]  REG_GOFS1     = 8'h04;
	localparam logic [7:0]  REG_DPTR0     = 8'h08;
	localparam logic [7:0]  REG_DPTR1     = 8'h0C;
	localparam logic [7:0]  REG_DOFS0     = 8'h10;
	localparam logic [7:0]  REG_DOFS1     = 8'h14;
	localparam logic [7:0]  REG_PAGE0     = 8'h18;
	localparam logic [7:0]  REG_CBP       = 8'h28;
	localparam logic [7:0]  REG_STRIDE    = 8'h04;
	localparam logic [15:0] GOFS_RESET    = 16'h0000;
	localparam logic [15:0] DPTR_RESET    = 16'h0000;
	localparam logic [15:0] DOFS_RESET    = 16'h0000;
	localparam logic [15:0] CBP_RESET     = 16'h0000;
	localparam logic [15:0] EVEN_MASK     = 16'hFFFE;
	localparam logic [15:0] WORD_STEP     = 16'h0002;
	localparam logic [15:0] BYTE_STEP     = 16'h0001;
	localparam logic [23:0] DUAL_PORT_DATA_RAM_BASE_DEF = 24'h000000;
	typedef enum logic [2:0] {
		STD_PLAIN,
		STD_PREDEC,
		STD_DISP,
		STD_POSTINC,
		STD_POSTDEC,
		STD_POSTINC_Q,
		STD_POSTDEC_Q
	} iag_std_mode_type;
	typedef enum logic [2:0] {
		DSP_PLAIN,
		DSP_INC2,
		DSP_DEC2,
		DSP_INCQ,
		DSP_DECQ
	} iag_dsp_mode_type;
endpackage
`default_nettype wire

/* iag_core.sv */
// indirect address generation: standard gpr pointer unit and dsp pointer unit
//
// Our own choices: the placing of the registers and the plain strobed port.
`default_nettype none
// Operation
// RULE_01: general offsets keep bits 15:1, bit 0 zero
// RULE_02: global bank: base pointer plus twice short address
// RULE_03: local bank: twice short address, no base
// RULE_04: any of sixteen word registers as pointer
// RULE_05: narrow instructions decode 2-bit register field
// RULE_06: pre-decrement by 1 or 2 before access
// RULE_07: displacement adds constant, pointer unchanged
// RULE_08: post-increment by 2 word, 1 byte
// RULE_09: post-decrement by 2 for words
// RULE_10: post-increment pointer by selected general offset
// RULE_11: post-decrement pointer by selected general offset
// RULE_12: page select registers give 24-bit address
// RULE_13: page or segment override replaces page select
// RULE_14: dsp pointer updates parallel to gpr update
// RULE_15: dsp unit uses only its two pointers
// RULE_16: dsp pointers keep bits 15:1, bit 0 zero
// RULE_17: mac arithmetic zero-extends dsp pointer
// RULE_18: mac arithmetic ignores pointer's top four bits
// RULE_19: mac move uses page select like gpr
// RULE_20: dsp pointers step by 2 or offset
// RULE_21: stall after offset or pointer write
// RULE_22: low 14 bits offset, top two pick page
// RULE_23: page override replaces page, segment prepends
// RULE_24: modified pointer written back to same register
module iag_core
	import iag_pkg::*;
#(
	parameter logic [23:0] DUAL_PORT_DATA_RAM_BASE = DUAL_PORT_DATA_RAM_BASE_DEF
)(
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	input  wire logic [7:0]       reg_addr_i,
	input  wire logic [15:0]      reg_wdata_i,
	input  wire logic             reg_wr_i,
	input  wire logic             reg_rd_i,
	output logic      [15:0]      reg_rdata_o,
	input  wire logic             std_valid_i,
	input  wire iag_std_mode_type std_mode_i,
	input  wire logic             std_byte_i,
	input  wire logic [3:0]       std_short_i,
	input  wire logic             std_narrow_i,
	input  wire logic             std_local_i,
	input  wire logic [15:0]      std_ptr_i,
	input  wire logic [15:0]      std_const_i,
	input  wire logic             std_qsel_i,
	input  wire logic             ovr_page_i,
	input  wire logic             ovr_seg_i,
	input  wire logic [9:0]       ovr_value_i,
	input  wire logic             dsp_valid_i,
	input  wire iag_dsp_mode_type dsp_mode_i,
	input  wire logic             dsp_sel_i,
	input  wire logic             dsp_qsel_i,
	input  wire logic             dsp_move_i,
	output logic      [15:0]      std_gpr_addr_o,
	output logic      [23:0]      std_phys_o,
	output logic      [15:0]      std_wb_data_o,
	output logic                  std_wb_en_o,
	output logic                  std_done_o,
	output logic      [23:0]      dsp_phys_o,
	output logic      [15:0]      dsp_ptr_o,
	output logic                  dsp_done_o,
	output logic                  stall_o
);

	logic [15:0] gofs_r [NUM_PAIR];
	logic [15:0] dofs_r [NUM_PAIR];
	logic [15:0] dptr_r [NUM_PAIR];
	logic [9:0]  page_r [NUM_PAGE];
	logic [15:0] cbp_r;
	logic [15:0] rdata_nxt;
	logic [15:0] std_step;
	logic [15:0] std_qofs;
	logic [15:0] std_pre;
	logic [15:0] std_long;
	logic [15:0] std_post;
	logic [3:0]  std_reg;
	logic [15:0] std_gpr_nxt;
	logic        std_wb_nxt;
	logic [15:0] dsp_cur;
	logic [15:0] dsp_qofs;
	logic [15:0] dsp_post;
	logic [23:0] dsp_phys_nxt;
	logic        dsp_upd;
	logic        stall_nxt;

	// long address to physical address through page select or override
	function automatic logic [23:0] iag_translate(
		input logic [15:0] long_addr,
		input logic        page_ovr,
		input logic        seg_ovr,
		input logic [9:0]  ovr_val,
		input logic [9:0]  page_sel
	);
		logic [9:0] page;
		page = page_ovr ? ovr_val : page_sel; // [RULE_13] [RULE_23]
		// a segment override takes the whole long address and wins over a page override
		if (seg_ovr)
		begin
			iag_translate = {ovr_val[SEG_W-1:0], long_addr}; // [RULE_13] [RULE_23]
		end
		else
		begin
			iag_translate = {page, long_addr[PAGE_OFS_W-1:0]}; // [RULE_12] [RULE_22]
		end
	endfunction

	// software-visible offset and pointer pairs
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PAIR; gi++)
		begin : g_pair
			localparam logic [7:0] GOFS_A = REG_GOFS0 + 8'(gi) * REG_STRIDE;
			localparam logic [7:0] DOFS_A = REG_DOFS0 + 8'(gi) * REG_STRIDE;
			localparam logic [7:0] DPTR_A = REG_DPTR0 + 8'(gi) * REG_STRIDE;

			// bit 0 of every offset and pointer is held at zero
			always_ff @(posedge clk_i or negedge reset_n_i)
			begin
				if (!reset_n_i)
				begin
					gofs_r[gi] <= GOFS_RESET;
				end
				else if (reg_wr_i && reg_addr_i == GOFS_A)
				begin
					gofs_r[gi] <= reg_wdata_i & EVEN_MASK; // [RULE_01]
				end
			end

			always_ff @(posedge clk_i or negedge reset_n_i)
			begin
				if (!reset_n_i)
				begin
					dofs_r[gi] <= DOFS_RESET;
				end
				else if (reg_wr_i && reg_addr_i == DOFS_A)
				begin
					dofs_r[gi] <= reg_wdata_i & EVEN_MASK;
				end
			end

			// software write wins over an instruction update in the same cycle
			always_ff @(posedge clk_i or negedge reset_n_i)
			begin
				if (!reset_n_i)
				begin
					dptr_r[gi] <= DPTR_RESET;
				end
				else if (reg_wr_i && reg_addr_i == DPTR_A)
				begin
					dptr_r[gi] <= reg_wdata_i & EVEN_MASK; // [RULE_16]
				end
				else if (dsp_upd && dsp_sel_i == 1'(gi))
				begin
					dptr_r[gi] <= dsp_post & EVEN_MASK; // [RULE_16] [RULE_20]
				end
			end
		end

		for (gi = 0; gi < NUM_PAGE; gi++)
		begin : g_page
			localparam logic [7:0] PAGE_A = REG_PAGE0 + 8'(gi) * REG_STRIDE;
			always_ff @(posedge clk_i or negedge reset_n_i)
			begin
				if (!reset_n_i)
				begin
					page_r[gi] <= 10'(gi);
				end
				else if (reg_wr_i && reg_addr_i == PAGE_A)
				begin
					page_r[gi] <= reg_wdata_i[PAGE_W-1:0];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			cbp_r <= CBP_RESET;
		end
		else if (reg_wr_i && reg_addr_i == REG_CBP)
		begin
			cbp_r <= reg_wdata_i & EVEN_MASK;
		end
	end

	// read mux; unmapped addresses read zero
	always_comb
	begin
		rdata_nxt = 16'h0000;
		unique case (reg_addr_i)
			REG_GOFS0: rdata_nxt = gofs_r[0];
			REG_GOFS1: rdata_nxt = gofs_r[1];
			REG_DPTR0: rdata_nxt = dptr_r[0];
			REG_DPTR1: rdata_nxt = dptr_r[1];
			REG_DOFS0: rdata_nxt = dofs_r[0];
			REG_DOFS1: rdata_nxt = dofs_r[1];
			REG_PAGE0: rdata_nxt = {6'h00, page_r[0]};
			REG_PAGE0 + REG_STRIDE: rdata_nxt = {6'h00, page_r[1]};
			REG_PAGE0 + 8'h08: rdata_nxt = {6'h00, page_r[2]};
			REG_PAGE0 + 8'h0C: rdata_nxt = {6'h00, page_r[3]};
			REG_CBP:   rdata_nxt = cbp_r;
			default:   rdata_nxt = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			reg_rdata_o <= 16'h0000;
		end
		else
		begin
			reg_rdata_o <= reg_rd_i ? rdata_nxt : 16'h0000;
		end
	end

	// one stall cycle lets the pipeline pick up a freshly written value
	always_comb
	begin
		stall_nxt = reg_wr_i && (reg_addr_i == REG_GOFS0 || reg_addr_i == REG_GOFS1 ||
			reg_addr_i == REG_DPTR0 || reg_addr_i == REG_DPTR1 ||
			reg_addr_i == REG_DOFS0 || reg_addr_i == REG_DOFS1); // [RULE_21]
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			stall_o <= 1'b0;
		end
		else
		begin
			stall_o <= stall_nxt; // [RULE_21]
		end
	end

	// standard unit
	always_comb
	begin
		std_reg = std_narrow_i ? {2'b00, std_short_i[1:0]} : std_short_i; // [RULE_04] [RULE_05]
		if (std_local_i)
		begin
			std_gpr_nxt = {11'h000, std_reg, 1'b0}; // [RULE_03]
		end
		else
		begin
			std_gpr_nxt = cbp_r + {11'h000, std_reg, 1'b0}; // [RULE_02]
		end
		std_step = std_byte_i ? BYTE_STEP : WORD_STEP;
		std_qofs = std_qsel_i ? gofs_r[1] : gofs_r[0];
		std_pre  = std_ptr_i;
		std_long = std_ptr_i;
		std_post = std_ptr_i;
		std_wb_nxt = 1'b1;
		unique case (std_mode_i)
			STD_PLAIN:
			begin
				std_wb_nxt = 1'b0;
			end
			STD_PREDEC:
			begin
				std_pre  = std_ptr_i - std_step; // [RULE_06]
				std_long = std_pre;
				std_post = std_pre;
			end
			STD_DISP:
			begin
				std_long   = std_ptr_i + std_const_i; // [RULE_07]
				std_wb_nxt = 1'b0;
			end
			STD_POSTINC:   std_post = std_ptr_i + std_step; // [RULE_08]
			STD_POSTDEC:   std_post = std_ptr_i - WORD_STEP; // [RULE_09]
			STD_POSTINC_Q: std_post = std_ptr_i + std_qofs; // [RULE_10]
			STD_POSTDEC_Q: std_post = std_ptr_i - std_qofs; // [RULE_11]
			default:       std_wb_nxt = 1'b0;
		endcase
	end

	// address outputs hold their value until the next request
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			std_gpr_addr_o <= 16'h0000;
			std_phys_o     <= 24'h000000;
			std_wb_data_o  <= 16'h0000;
		end
		else if (std_valid_i)
		begin
			std_gpr_addr_o <= std_gpr_nxt;
			std_phys_o     <= iag_translate(std_long, ovr_page_i, ovr_seg_i, ovr_value_i,
				page_r[std_long[PAGE_SEL_HI:PAGE_SEL_LO]]); // [RULE_12]
			std_wb_data_o  <= std_post; // [RULE_24]
		end
	end

	// done and write-back strobes last one cycle
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			std_done_o  <= 1'b0;
			std_wb_en_o <= 1'b0;
		end
		else
		begin
			std_done_o  <= std_valid_i;
			std_wb_en_o <= std_valid_i && std_wb_nxt; // [RULE_24]
		end
	end

	// dsp unit: own adder, runs beside the standard unit
	always_comb
	begin
		dsp_cur  = dsp_sel_i ? dptr_r[1] : dptr_r[0]; // [RULE_15]
		dsp_qofs = dsp_qsel_i ? dofs_r[1] : dofs_r[0];
		dsp_upd  = dsp_valid_i;
		unique case (dsp_mode_i)
			DSP_INC2: dsp_post = dsp_cur + WORD_STEP; // [RULE_20]
			DSP_DEC2: dsp_post = dsp_cur - WORD_STEP; // [RULE_20]
			DSP_INCQ: dsp_post = dsp_cur + dsp_qofs; // [RULE_20]
			DSP_DECQ: dsp_post = dsp_cur - dsp_qofs; // [RULE_20]
			default:
			begin
				dsp_post = dsp_cur;
				dsp_upd  = 1'b0;
			end
		endcase
		if (dsp_move_i)
		begin
			dsp_phys_nxt = iag_translate(dsp_cur, ovr_page_i, ovr_seg_i, ovr_value_i,
				page_r[dsp_cur[PAGE_SEL_HI:PAGE_SEL_LO]]); // [RULE_19]
		end
		else
		begin
			// top four bits dropped: the window never leaves the dual-port ram
			dsp_phys_nxt = DUAL_PORT_DATA_RAM_BASE | {12'h000, dsp_cur[DUAL_PORT_DATA_RAM_OFS_W-1:0]}; // [RULE_17] [RULE_18]
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			dsp_phys_o <= 24'h000000;
			dsp_ptr_o  <= 16'h0000;
		end
		else if (dsp_valid_i)
		begin
			dsp_phys_o <= dsp_phys_nxt; // [RULE_14]
			dsp_ptr_o  <= dsp_post & EVEN_MASK;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			dsp_done_o <= 1'b0;
		end
		else
		begin
			dsp_done_o <= dsp_valid_i;
		end
	end

endmodule
`default_nettype wire

/* iag_core_asserts.sv */
// assertion checker on the ports of the address generation core
`default_nettype none
module iag_core_asserts
	import iag_pkg::*;
#(
	parameter logic [23:0] DUAL_PORT_DATA_RAM_BASE = DUAL_PORT_DATA_RAM_BASE_DEF
)(
	input wire logic             clk_i,
	input wire logic             reset_n_i,
	input wire logic [7:0]       reg_addr_i,
	input wire logic             reg_wr_i,
	input wire logic             std_valid_i,
	input wire iag_std_mode_type std_mode_i,
	input wire logic             std_byte_i,
	input wire logic [15:0]      std_ptr_i,
	input wire logic             ovr_seg_i,
	input wire logic [9:0]       ovr_value_i,
	input wire logic             dsp_valid_i,
	input wire iag_dsp_mode_type dsp_mode_i,
	input wire logic             dsp_move_i,
	input wire logic [23:0]      std_phys_o,
	input wire logic [15:0]      std_wb_data_o,
	input wire logic             std_wb_en_o,
	input wire logic [23:0]      dsp_phys_o,
	input wire logic [15:0]      dsp_ptr_o,
	input wire logic             stall_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);
	a_predec_step:
	assert property (std_valid_i && std_mode_i == STD_PREDEC |=>
		std_wb_data_o + ($past(std_byte_i) ? BYTE_STEP : WORD_STEP) == $past(std_ptr_i))
	else $error("predecrement value wrong");
	a_postinc_step:
	assert property (std_valid_i && std_mode_i == STD_POSTINC |=> std_wb_en_o &&
		std_wb_data_o == $past(std_ptr_i) + ($past(std_byte_i) ? BYTE_STEP : WORD_STEP))
	else $error("postincrement value wrong");
	a_postdec_word:
	assert property (std_valid_i && std_mode_i == STD_POSTDEC |=>
		std_wb_data_o + WORD_STEP == $past(std_ptr_i))
	else $error("postdecrement value wrong");
	a_disp_no_wb:
	assert property (std_valid_i && std_mode_i == STD_DISP |=> !std_wb_en_o)
	else $error("displacement wrote pointer back");
	a_seg_override:
	assert property (std_valid_i && ovr_seg_i && std_mode_i == STD_PLAIN |=>
		std_phys_o == {$past(ovr_value_i[7:0]), $past(std_ptr_i)})
	else $error("segment override address wrong");
	a_stall_pulse:
	assert property (reg_wr_i && reg_addr_i < REG_PAGE0 && reg_addr_i[1:0] == 2'b00 |=>
		stall_o)
	else $error("stall pulse missing");
	a_stall_idle:
	assert property (!(reg_wr_i && reg_addr_i < REG_PAGE0 && reg_addr_i[1:0] == 2'b00) |=>
		!stall_o)
	else $error("stall without offset or pointer write");
	a_dual_port_data_ram_map:
	assert property (dsp_valid_i && !dsp_move_i |=> dsp_phys_o[23:12] == DUAL_PORT_DATA_RAM_BASE[23:12])
	else $error("dsp address outside dual_port_data_ram");
	a_dsp_inc2:
	assert property (dsp_valid_i && dsp_mode_i == DSP_INC2 && !dsp_move_i |=>
		dsp_ptr_o[11:0] == dsp_phys_o[11:0] + 12'h002)
	else $error("dsp pointer step wrong");
endmodule
bind iag_core iag_core_asserts #(.DUAL_PORT_DATA_RAM_BASE(DUAL_PORT_DATA_RAM_BASE)) chk_u (
	.clk_i, .reset_n_i, .reg_addr_i, .reg_wr_i, .std_valid_i, .std_mode_i, .std_byte_i,
	.std_ptr_i, .ovr_seg_i, .ovr_value_i, .dsp_valid_i, .dsp_mode_i, .dsp_move_i,
	.std_phys_o, .std_wb_data_o, .std_wb_en_o, .dsp_phys_o, .dsp_ptr_o, .stall_o
);
`default_nettype wire

/* iag_pipe_model.sv */
// pipeline-side register file that supplies pointers and takes them back
`default_nettype none
module iag_pipe_model (
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        std_valid_i,
	input  wire logic [3:0]  std_short_i,
	input  wire logic        std_narrow_i,
	input  wire logic        wb_en_i,
	input  wire logic [15:0] wb_data_i,
	output logic      [15:0] std_ptr_o
);
	logic [15:0] gpr_r [16];
	logic [3:0]  idx_r;
	logic [3:0]  idx;
	assign idx = std_narrow_i ? {2'b00, std_short_i[1:0]} : std_short_i;
	assign std_ptr_o = gpr_r[idx];
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			for (int i = 0; i < 16; i++)
				gpr_r[i] <= 16'h3C00 + 16'(i * 16'h0452);
			idx_r <= 4'h0;
		end
		else
		begin
			if (std_valid_i)
				idx_r <= idx;
			if (wb_en_i)
				gpr_r[idx_r] <= wb_data_i;
		end
	end
endmodule
`default_nettype wire

/* iag_core_tb.sv */
// self-checking bench for the indirect address generation core
`default_nettype none
module iag_core_tb
	import iag_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i, reset_n_i, reg_wr_i, reg_rd_i, std_valid_i, std_byte_i, std_narrow_i;
	logic        std_local_i, std_qsel_i, ovr_page_i, ovr_seg_i, dsp_valid_i, dsp_sel_i, we;
	logic        dsp_qsel_i, dsp_move_i, std_wb_en_o, std_done_o, dsp_done_o, stall_o;
	logic [3:0]  std_short_i;
	logic [7:0]  reg_addr_i;
	logic [9:0]  ovr_value_i;
	logic [15:0] reg_wdata_i, reg_rdata_o, std_ptr_i, std_const_i, std_gpr_addr_o, rv[12];
	logic [15:0] std_wb_data_o, dsp_ptr_o, wb, la, ga, p, np;
	logic [23:0] std_phys_o, dsp_phys_o, ep, ed;
	logic [31:0] lfsr_r, r;
	int          mismatches, comparisons;
	iag_std_mode_type std_mode_i;
	iag_dsp_mode_type dsp_mode_i;
	iag_core dut_u (.clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
		.reg_rdata_o, .std_valid_i, .std_mode_i, .std_byte_i, .std_short_i, .std_narrow_i,
		.std_local_i, .std_ptr_i, .std_const_i, .std_qsel_i, .ovr_page_i, .ovr_seg_i,
		.ovr_value_i, .dsp_valid_i, .dsp_mode_i, .dsp_sel_i, .dsp_qsel_i, .dsp_move_i,
		.std_gpr_addr_o, .std_phys_o, .std_wb_data_o, .std_wb_en_o, .std_done_o,
		.dsp_phys_o, .dsp_ptr_o, .dsp_done_o, .stall_o);
	iag_pipe_model pm_u (.clk_i, .reset_n_i, .std_valid_i, .std_short_i, .std_narrow_i,
		.wb_en_i(std_wb_en_o), .wb_data_i(std_wb_data_o), .std_ptr_o(std_ptr_i));
	function automatic logic [31:0] rnd();
		lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
		return lfsr_r;
	endfunction
	function automatic logic [23:0] xlate(input logic [15:0] a);
		if (ovr_seg_i)
			return {ovr_value_i[7:0], a};
		if (ovr_page_i)
			return {ovr_value_i, a[13:0]};
		return {rv[6 + a[15:14]][9:0], a[13:0]};
	endfunction
	task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
		comparisons++;
		if (s !== e)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		reg_wr_i    <= 1'b1;
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk_i);
		reg_rd_i   <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk("rdata", reg_rdata_o, e);
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	initial
	begin
		{reset_n_i, reg_wr_i, reg_rd_i, std_valid_i, std_byte_i, std_narrow_i} = '0;
		{std_local_i, std_qsel_i, ovr_page_i, ovr_seg_i, dsp_valid_i, dsp_sel_i} = '0;
		{dsp_qsel_i, dsp_move_i, std_short_i, reg_addr_i, ovr_value_i} = '0;
		{reg_wdata_i, std_const_i, mismatches, comparisons} = '0;
		std_mode_i = STD_PLAIN;
		dsp_mode_i = DSP_PLAIN;
		lfsr_r = 32'hE1C69181;
		repeat (4) @(posedge clk_i);
		reset_n_i <= 1'b1;
		for (int i = 0; i < 12; i++)
			rv[i] = (i > 5 && i < 10) ? 16'(i - 6) : 16'h0000;
		for (int i = 0; i < 12; i++)
			rd(8'(4 * i), rv[i]);
		for (int i = 0; i < 12; i++)
		begin
			r = rnd();
			wr(8'(4 * i), r[15:0] | 16'h0001);
			chk("stall", stall_o, i < 6);
			if (i < 11)
				rv[i] = (i > 5 && i < 10) ? {6'h00, r[9:1], 1'b1} : r[15:0] & EVEN_MASK;
		end
		for (int i = 0; i < 12; i++)
			rd(8'(4 * i), rv[i]);
		for (int n = 0; n < 140; n++)
		begin
			r = rnd();
			@(posedge clk_i);
			{std_valid_i, dsp_valid_i} <= 2'b11;
			std_mode_i   <= iag_std_mode_type'(n % 7);
			dsp_mode_i   <= iag_dsp_mode_type'(n % 5);
			std_byte_i   <= r[0] && (n % 7) < 4;
			{std_short_i, std_narrow_i, std_local_i, std_qsel_i} <= r[7:1];
			{ovr_page_i, ovr_seg_i} <= n < 14 ? 2'b00 : r[9:8];
			{ovr_value_i, std_const_i} <= {r[19:10], r[31:16]};
			{dsp_sel_i, dsp_qsel_i, dsp_move_i} <= r[22:20];
			#1;
			case (std_mode_i)
				STD_PREDEC:    wb = std_ptr_i - (std_byte_i ? BYTE_STEP : WORD_STEP);
				STD_POSTINC:   wb = std_ptr_i + (std_byte_i ? BYTE_STEP : WORD_STEP);
				STD_POSTDEC:   wb = std_ptr_i - WORD_STEP;
				STD_POSTINC_Q: wb = std_ptr_i + rv[std_qsel_i];
				STD_POSTDEC_Q: wb = std_ptr_i - rv[std_qsel_i];
				default:       wb = std_ptr_i;
			endcase
			we = std_mode_i != STD_PLAIN && std_mode_i != STD_DISP;
			la = std_mode_i == STD_PREDEC ? wb : std_ptr_i;
			ep = xlate(std_mode_i == STD_DISP ? std_ptr_i + std_const_i : la);
			ga = {11'h000, std_narrow_i ? {2'b00, std_short_i[1:0]} : std_short_i, 1'b0};
			ga = ga + (std_local_i ? 16'h0000 : rv[10]);
			p  = rv[2 + dsp_sel_i];
			ed = dsp_move_i ? xlate(p) : DUAL_PORT_DATA_RAM_BASE_DEF | {12'h000, p[11:0]};
			case (dsp_mode_i)
				DSP_INC2: np = p + WORD_STEP;
				DSP_DEC2: np = p - WORD_STEP;
				DSP_INCQ: np = p + rv[4 + dsp_qsel_i];
				DSP_DECQ: np = p - rv[4 + dsp_qsel_i];
				default:  np = p;
			endcase
			@(posedge clk_i);
			{std_valid_i, dsp_valid_i} <= 2'b00;
			#1;
			chk("gpr_addr", std_gpr_addr_o, ga);
			chk("phys", std_phys_o, ep);
			chk("wb_en", std_wb_en_o, we);
			if (we)
				chk("wb_data", std_wb_data_o, wb);
			chk("done", {std_done_o, dsp_done_o}, 2'b11);
			chk("dsp_phys", dsp_phys_o, ed);
			chk("dsp_ptr", dsp_ptr_o, np);
			rv[2 + dsp_sel_i] = np;
		end
		// corner: a software pointer write beats a same-cycle dsp update
		@(posedge clk_i);
		{reg_wr_i, dsp_valid_i, dsp_sel_i, dsp_move_i} <= 4'b1100;
		reg_addr_i  <= REG_DPTR0;
		reg_wdata_i <= 16'h8E45;
		dsp_mode_i  <= DSP_INC2;
		@(posedge clk_i);
		{reg_wr_i, dsp_valid_i} <= 2'b00;
		rv[2] = 16'h8E44;
		rd(REG_DPTR0, rv[2]);
		rd(REG_DPTR1, rv[3]);
		complete_run();
	end
endmodule
`default_nettype wire
